// File: design/mmft_top.sv
`timescale 1ns/10ps
`include "mmft_params.svh"

module mmft_top #(
	parameter int unsigned MS_CYCLES = `MMFT_MS_CYCLES
) (
	// module clock
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// link oversampling clock
	input wire logic i_link_clk,
	// management bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_module_select_n,
	// host control pin
	input wire logic i_low_power_pin,
	// lane conditions
	input wire logic [3:0] i_rx_los,
	input wire logic [3:0] i_tx_los,
	input wire logic [3:0] i_rx_lol,
	input wire logic [3:0] i_tx_lol,
	// lane and module controls
	output logic [3:0] o_tx_output_en,
	output logic [3:0] o_rx_output_en,
	output logic o_low_power,
	output logic o_ready,
	output logic o_interrupt_request_n
);

	mmft_pkg::mmft_link_t l_reg;
	mmft_pkg::mmft_link_t l_next;
	mmft_pkg::mmft_main_t m_reg;
	mmft_pkg::mmft_main_t m_next;

	// byte seen by the host at an address
	// unmapped bytes and other pages read as zero
	function automatic logic [7:0] rd_byte(input mmft_pkg::mmft_main_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `MMFT_OFF_LOS) begin
			v = s.flag_los;
		end else if (a == `MMFT_OFF_FAULT) begin
			v = 8'h00;
		end else if (a == `MMFT_OFF_LOL) begin
			v = s.flag_lol;
		end else if (a == `MMFT_OFF_TXDIS) begin
			v = {4'h0, s.txdis};
		end else if (a == `MMFT_OFF_PWR) begin
			v = {6'h00, s.pwr};
		end else if (a == `MMFT_OFF_MASK_LOS) begin
			v = s.mask_los;
		end else if (a == `MMFT_OFF_MASK_FAULT) begin
			v = s.mask_fault;
		end else if (a == `MMFT_OFF_MASK_LOL) begin
			v = s.mask_lol;
		end else if (a == `MMFT_OFF_PAGE) begin
			v = s.page;
		end else if (a >= `MMFT_UPPER_BASE && s.page == `MMFT_PAGE_CTL) begin
			if (a == `MMFT_OFF_SQDIS) begin
				v = {4'h0, s.sqdis};
			end else if (a == `MMFT_OFF_RXDIS) begin
				v = {s.rxdis, 4'h0};
			end
		end
		return v;
	endfunction

	// link domain: bus target, oversampled
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic rd_ok;

	always_comb begin
		l_next = l_reg;
		l_next.scl_m = i_scl;
		l_next.scl_s = l_reg.scl_m;
		l_next.scl_p = l_reg.scl_s;
		l_next.sda_m = i_sda;
		l_next.sda_s = l_reg.sda_m;
		l_next.sda_p = l_reg.sda_s;
		l_next.sel_m = i_module_select_n;
		l_next.sel_s = l_reg.sel_m;
		l_next.ack_m = m_reg.ack_tgl;
		l_next.ack_s = l_reg.ack_m;
		// an scl edge is seen after one link clock per phase; start and stop need scl high for two
		scl_rise = l_reg.scl_s & ~l_reg.scl_p;
		scl_fall = ~l_reg.scl_s & l_reg.scl_p;
		bus_start = l_reg.scl_s & l_reg.scl_p & l_reg.sda_p & ~l_reg.sda_s;
		bus_stop = l_reg.scl_s & l_reg.scl_p & ~l_reg.sda_p & l_reg.sda_s;
		// answer is trusted only once the handshake has closed
		rd_ok = (l_reg.ack_s == l_reg.req_tgl);
		if (l_reg.sel_s) begin
			// never stretches scl, so releasing sda frees both lines
			l_next.state = mmft_pkg::LS_IDLE;
			l_next.sda_oe = 1'b0;
		end else if (bus_start) begin
			l_next.state = mmft_pkg::LS_ADDR;
			l_next.bitcnt = 4'h0;
			l_next.sda_oe = 1'b0;
		end else if (bus_stop) begin
			l_next.state = mmft_pkg::LS_IDLE;
			l_next.sda_oe = 1'b0;
		end else begin
			case (l_reg.state)
				mmft_pkg::LS_IDLE: begin
					l_next.sda_oe = 1'b0;
				end
				mmft_pkg::LS_ADDR: begin
					if (scl_rise) begin
						l_next.shift = {l_reg.shift[6:0], l_reg.sda_s};
						l_next.bitcnt = l_reg.bitcnt + 4'h1;
						if (l_reg.bitcnt == 4'h7) begin
							if (l_next.shift[7:1] == `MMFT_DEV_ADDR) begin
								l_next.state = mmft_pkg::LS_ADDR_ACK;
								l_next.rw = l_next.shift[0];
								l_next.first = 1'b1;
								// a read asks for its byte now, ahead of the ack bit
								if (l_next.shift[0]) begin
									l_next.req_wr = 1'b0;
									l_next.req_addr = l_reg.ptr;
									l_next.req_tgl = ~l_reg.req_tgl;
								end
							end else begin
								l_next.state = mmft_pkg::LS_IDLE;
							end
						end
					end
				end
				mmft_pkg::LS_ADDR_ACK: begin
					if (scl_fall) begin
						if (!l_reg.sda_oe) begin
							l_next.sda_oe = 1'b1;
						end else if (l_reg.rw) begin
							l_next.state = mmft_pkg::LS_RD;
							l_next.shift = rd_ok ? m_reg.rdata : 8'hFF;
							l_next.sda_oe = ~l_next.shift[7];
							l_next.bitcnt = 4'h0;
						end else begin
							l_next.state = mmft_pkg::LS_WR;
							l_next.sda_oe = 1'b0;
							l_next.bitcnt = 4'h0;
						end
					end
				end
				mmft_pkg::LS_WR: begin
					if (scl_rise) begin
						l_next.shift = {l_reg.shift[6:0], l_reg.sda_s};
						l_next.bitcnt = l_reg.bitcnt + 4'h1;
						if (l_reg.bitcnt == 4'h7) begin
							l_next.state = mmft_pkg::LS_WR_ACK;
							l_next.first = 1'b0;
							if (l_reg.first) begin
								l_next.ptr = l_next.shift;
							end else begin
								l_next.req_wr = 1'b1;
								l_next.req_addr = l_reg.ptr;
								l_next.req_data = l_next.shift;
								l_next.req_tgl = ~l_reg.req_tgl;
								l_next.ptr = l_reg.ptr + 8'h01;
							end
						end
					end
				end
				mmft_pkg::LS_WR_ACK: begin
					if (scl_fall) begin
						if (!l_reg.sda_oe) begin
							l_next.sda_oe = 1'b1;
						end else begin
							l_next.state = mmft_pkg::LS_WR;
							l_next.sda_oe = 1'b0;
							l_next.bitcnt = 4'h0;
						end
					end
				end
				mmft_pkg::LS_RD: begin
					if (scl_fall) begin
						if (l_reg.bitcnt == 4'h7) begin
							l_next.sda_oe = 1'b0;
							l_next.state = mmft_pkg::LS_RD_ACK;
							l_next.bitcnt = 4'h0;
						end else begin
							l_next.shift = {l_reg.shift[6:0], 1'b0};
							l_next.sda_oe = ~l_next.shift[7];
							l_next.bitcnt = l_reg.bitcnt + 4'h1;
						end
					end
				end
				mmft_pkg::LS_RD_ACK: begin
					if (scl_rise && l_reg.bitcnt == 4'h0) begin
						l_next.ptr = l_reg.ptr + 8'h01;
						if (l_reg.sda_s) begin
							l_next.state = mmft_pkg::LS_IDLE;
						end else begin
							l_next.req_wr = 1'b0;
							l_next.req_addr = l_next.ptr;
							l_next.req_tgl = ~l_reg.req_tgl;
							l_next.bitcnt = 4'h8;
						end
					end else if (scl_fall && l_reg.bitcnt == 4'h8) begin
						l_next.state = mmft_pkg::LS_RD;
						l_next.shift = rd_ok ? m_reg.rdata : 8'hFF;
						l_next.sda_oe = ~l_next.shift[7];
						l_next.bitcnt = 4'h0;
					end
				end
				default: begin
					l_next.state = mmft_pkg::LS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			l_reg <= '0;
			l_reg.scl_m <= 1'b1;
			l_reg.scl_s <= 1'b1;
			l_reg.scl_p <= 1'b1;
			l_reg.sda_m <= 1'b1;
			l_reg.sda_s <= 1'b1;
			l_reg.sda_p <= 1'b1;
			l_reg.sel_m <= 1'b1;
			l_reg.sel_s <= 1'b1;
			l_reg.state <= mmft_pkg::LS_IDLE;
		end else begin
			l_reg <= l_next;
		end
	end

	// module-clock domain: memory, flags, lane controls
	logic [7:0] los_now;
	logic [7:0] lol_now;
	logic ms_tick;
	logic [3:0] squelch;
	logic [15:0] unmasked;

	always_comb begin
		m_next = m_reg;
		m_next.req_m = l_reg.req_tgl;
		m_next.req_s = m_reg.req_m;
		m_next.req_p = m_reg.req_s;
		m_next.cond_m = {i_tx_lol, i_rx_lol, i_tx_los, i_rx_los};
		m_next.cond_s = m_reg.cond_m;
		m_next.lp_m = i_low_power_pin;
		m_next.lp_s = m_reg.lp_m;
		los_now = m_reg.cond_s[7:0];
		lol_now = m_reg.cond_s[15:8];
		// request words are stable once the toggle has crossed
		if (m_reg.req_s != m_reg.req_p) begin
			m_next.ack_tgl = ~m_reg.ack_tgl;
			// writes to flag bytes and unmapped bytes are dropped
			if (l_reg.req_wr) begin
				if (l_reg.req_addr == `MMFT_OFF_TXDIS) begin
					m_next.txdis = l_reg.req_data[3:0];
				end else if (l_reg.req_addr == `MMFT_OFF_PWR) begin
					m_next.pwr = l_reg.req_data[1:0];
				end else if (l_reg.req_addr == `MMFT_OFF_MASK_LOS) begin
					m_next.mask_los = l_reg.req_data;
				end else if (l_reg.req_addr == `MMFT_OFF_MASK_FAULT) begin
					m_next.mask_fault = l_reg.req_data;
				end else if (l_reg.req_addr == `MMFT_OFF_MASK_LOL) begin
					m_next.mask_lol = l_reg.req_data;
				end else if (l_reg.req_addr == `MMFT_OFF_PAGE) begin
					m_next.page = l_reg.req_data;
				end else if (m_reg.page == `MMFT_PAGE_CTL && l_reg.req_addr == `MMFT_OFF_SQDIS) begin
					m_next.sqdis = l_reg.req_data[3:0];
				end else if (m_reg.page == `MMFT_PAGE_CTL && l_reg.req_addr == `MMFT_OFF_RXDIS) begin
					m_next.rxdis = l_reg.req_data[7:4];
				end
			end else begin
				m_next.rdata = rd_byte(m_reg, l_reg.req_addr);
				if (l_reg.req_addr == `MMFT_OFF_LOS) begin
					m_next.flag_los = 8'h00;
				end else if (l_reg.req_addr == `MMFT_OFF_LOL) begin
					m_next.flag_lol = 8'h00;
				end
			end
		end
		// condition still present re-sets the flag, set beats clear
		m_next.flag_los = m_next.flag_los | los_now;
		m_next.flag_lol = m_next.flag_lol | lol_now;
		// slow timebase for the ms-scale ready settle count
		ms_tick = (m_reg.ms_cnt == 16'(MS_CYCLES - 1));
		m_next.ms_cnt = ms_tick ? 16'h0000 : m_reg.ms_cnt + 16'h0001;
		// override chooses register over pin
		if (m_reg.pwr[`MMFT_PWR_OVR_BIT]) begin
			m_next.low_power = m_reg.pwr[`MMFT_PWR_SET_BIT];
		end else begin
			m_next.low_power = m_reg.lp_s;
		end
		// ready only after the settle count of ms ticks
		if (m_next.low_power) begin
			m_next.ready = 1'b0;
			m_next.settle = 9'h000;
		end else if (!m_reg.ready && ms_tick) begin
			m_next.settle = m_reg.settle + 9'h001;
			if (m_reg.settle == `MMFT_PWR_SETTLE_MS - 9'h001) begin
				m_next.ready = 1'b1;
			end
		end
		unmasked = {m_next.flag_los & ~m_next.mask_los, m_next.flag_lol & ~m_next.mask_lol};
		// one cycle from flag or mask change to pin, far inside the limits
		m_next.int_n = ~|unmasked;
		squelch = m_reg.cond_s[7:4] & ~m_next.sqdis;
		m_next.tx_en = {4{m_next.ready}} & ~m_next.txdis & ~squelch;
		m_next.rx_en = {4{m_next.ready}} & ~m_next.rxdis;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			m_reg <= '0;
			m_reg.mask_los <= `MMFT_RST_BYTE;
			m_reg.mask_fault <= `MMFT_RST_BYTE;
			m_reg.mask_lol <= `MMFT_RST_BYTE;
			m_reg.txdis <= `MMFT_RST_LANES;
			m_reg.sqdis <= `MMFT_RST_LANES;
			m_reg.rxdis <= `MMFT_RST_LANES;
			m_reg.pwr <= `MMFT_RST_PWR;
			// pin idles high, so start in low power
			m_reg.lp_m <= 1'b1;
			m_reg.lp_s <= 1'b1;
			m_reg.low_power <= 1'b1;
			m_reg.int_n <= 1'b1;
		end else if (i_ce) begin
			m_reg <= m_next;
		end
	end

	// open drain: the pin is only ever pulled low
	assign o_sda = 1'b0;
	assign o_sda_oe = l_reg.sda_oe;
	assign o_tx_output_en = m_reg.tx_en;
	assign o_rx_output_en = m_reg.rx_en;
	assign o_low_power = m_reg.low_power;
	assign o_ready = m_reg.ready;
	assign o_interrupt_request_n = m_reg.int_n;

endmodule // mmft_top

// File: dv/mmft_host_model.sv
`timescale 1ns/10ps
`include "mmft_params.svh"
module mmft_host_model #(
	parameter int SETUP = 16
) (
	// link clock and data wire
	input wire logic i_link_clk,
	input wire logic i_sda,
	// host driven lines
	output logic o_scl,
	output logic o_sda_pull,
	output logic o_select_n
);
	logic [7:0] rbuf [4];
	logic ack_ok = 1'b1;
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
		o_select_n = 1'b1;
	end
	// quarter bit of 4 link clocks keeps scl near 390 kHz
	task automatic wq();
		repeat (4) @(posedge i_link_clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		o_sda_pull <= !b;
		wq();
		o_scl <= 1'b1;
		wq();
		r = i_sda;
		wq();
		o_scl <= 1'b0;
		wq();
	endtask
	task automatic start();
		o_sda_pull <= 1'b0;
		wq();
		o_scl <= 1'b1;
		wq();
		o_sda_pull <= 1'b1;
		wq();
		o_scl <= 1'b0;
		wq();
	endtask
	task automatic byte_io(input logic [7:0] d, input logic m, c, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(m, a);
		if (c && a)
			ack_ok = 1'b0;
	endtask
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] p, wd,
		input int n);
		logic [7:0] r;
		ack_ok = 1'b1;
		@(posedge i_link_clk);
		o_select_n <= 1'b0;
		repeat (SETUP) @(posedge i_link_clk);
		start();
		byte_io({a, 1'b0}, 1'b1, 1'b1, r);
		byte_io(p, 1'b1, 1'b1, r);
		if (rd) begin
			start();
			byte_io({a, 1'b1}, 1'b1, 1'b1, r);
			for (int i = 0; i < n; i++)
				byte_io(8'hFF, i == n - 1, 1'b0, rbuf[i]);
		end else
			byte_io(wd, 1'b1, 1'b1, r);
		o_sda_pull <= 1'b1;
		wq();
		o_scl <= 1'b1;
		wq();
		o_sda_pull <= 1'b0;
		repeat (SETUP) @(posedge i_link_clk);
		o_select_n <= 1'b1;
	endtask
	task automatic abort();
		logic [7:0] d;
		logic r;
		d = {`MMFT_DEV_ADDR, 1'b0};
		@(posedge i_link_clk);
		o_select_n <= 1'b0;
		repeat (SETUP) @(posedge i_link_clk);
		start();
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		o_sda_pull <= 1'b0;
		wq();
		wq();
		ack_ok = !i_sda;
		// deselect while the target still drives its ack
		o_select_n <= 1'b1;
		wq();
		o_scl <= 1'b1;
	endtask
endmodule // mmft_host_model

// File: dv/mmft_monitor.sv
`timescale 1ns/10ps
module mmft_monitor #(
	parameter int unsigned MS_CYCLES = 50000
) (
	// clocks and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_link_clk,
	// pins in
	input wire logic i_scl,
	input wire logic i_module_select_n,
	input wire logic i_low_power_pin,
	input wire logic [3:0] i_rx_los,
	// pins out
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic [3:0] o_tx_output_en,
	input wire logic [3:0] o_rx_output_en,
	input wire logic o_low_power,
	input wire logic o_ready,
	input wire logic o_interrupt_request_n
);
	localparam int T100 = 100 * MS_CYCLES;
	localparam int T300 = 300 * MS_CYCLES;
	// 300 ms is past any delay range, so count it
	logic [31:0] wait_reg;
	logic [31:0] wait_next;
	always_comb begin
		wait_next = (o_low_power || o_ready) ? 32'h0 : wait_reg + 32'h1;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			wait_reg <= 32'h0;
		else
			wait_reg <= wait_next;
	end
	chk_los_int_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_rx_los[0]) |-> ##[1:T100] !o_interrupt_request_n)
		else $error("rx loss did not raise the interrupt in time");
	chk_int_idle_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_resetn) |-> o_interrupt_request_n)
		else $error("interrupt active right after reset");
	chk_lp_pin_enter: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_low_power_pin) |-> ##[1:T100] o_low_power)
		else $error("low power not entered in time");
	chk_lp_not_ready: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_low_power [*3] |-> !o_ready)
		else $error("ready while in low power");
	chk_ready_settle: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wait_reg <= T300)
		else $error("not ready long after power down cleared");
	chk_ready_tx_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_ready [*2] |-> o_tx_output_en == 4'h0)
		else $error("optical output on while not ready");
	chk_rx_no_squelch: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$rose(i_rx_los[3]) && o_rx_output_en[3] && o_ready && !i_low_power_pin
		|=> o_rx_output_en[3] [*8])
		else $error("rx output squelched on input loss");
	chk_sda_open_drain: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
		o_sda == 1'b0)
		else $error("data pin value not low");
	chk_abort_release: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
		i_module_select_n [*8] |=> !o_sda_oe)
		else $error("data line held after deselect");
	chk_oe_scl_low: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
		$changed(o_sda_oe) && !i_module_select_n |-> !i_scl)
		else $error("data changed while clock high");
	cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(o_interrupt_request_n));
	cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_ready));
	cover property (@(posedge i_link_clk) disable iff (!i_resetn) $rose(o_sda_oe));
endmodule // mmft_monitor

bind mmft_top mmft_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(i_link_clk), .i_scl(i_scl),
	.i_module_select_n(i_module_select_n), .i_low_power_pin(i_low_power_pin),
	.i_rx_los(i_rx_los), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
	.o_tx_output_en(o_tx_output_en), .o_rx_output_en(o_rx_output_en),
	.o_low_power(o_low_power), .o_ready(o_ready),
	.o_interrupt_request_n(o_interrupt_request_n)
);

// File: dv/tb.sv
`timescale 1ns/10ps
`include "mmft_params.svh"
module tb;
	localparam int MSC = 10;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b0;
	logic lp_pin = 1'b1;
	logic ce = 1'b1;
	logic [3:0] rx_los = 4'h0;
	logic [3:0] tx_los = 4'h0;
	logic [3:0] rx_lol = 4'h0;
	logic [3:0] tx_lol = 4'h0;
	logic scl, sda_pull, sel_n, sda_oe, low_power, ready, int_n;
	logic [3:0] tx_en, rx_en;
	wire sda_w = !(sda_pull || sda_oe);
	int failures = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	initial begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	mmft_top #(.MS_CYCLES(MSC)) dut_u (
		.i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_link_clk(link_clk),
		.i_scl(scl), .i_sda(sda_w), .o_sda(), .o_sda_oe(sda_oe),
		.i_module_select_n(sel_n), .i_low_power_pin(lp_pin),
		.i_rx_los(rx_los), .i_tx_los(tx_los), .i_rx_lol(rx_lol), .i_tx_lol(tx_lol),
		.o_tx_output_en(tx_en), .o_rx_output_en(rx_en), .o_low_power(low_power),
		.o_ready(ready), .o_interrupt_request_n(int_n)
	);
	mmft_host_model host_u (
		.i_link_clk(link_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_pull(sda_pull),
		.o_select_n(sel_n)
	);
	task automatic check(input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] probe(input int k);
		case (k)
			0: return {7'h00, int_n};
			1: return {4'h0, tx_en};
			2: return {4'h0, rx_en};
			3: return {7'h00, low_power};
			4: return {7'h00, ready};
			default: return {7'h00, sda_oe};
		endcase
	endfunction
	task automatic expect_within(input int k, input logic [7:0] v, input int lim);
		for (int n = 0; n < lim && probe(k) !== v; n++)
			@(negedge clk);
		check(probe(k), v);
	endtask
	task automatic wr(input logic [7:0] p, d);
		host_u.xfer(`MMFT_DEV_ADDR, 1'b0, p, d, 1);
		@(negedge clk);
		check({7'h00, host_u.ack_ok}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		host_u.xfer(`MMFT_DEV_ADDR, 1'b1, p, 8'h00, n);
		@(negedge clk);
		check({7'h00, host_u.ack_ok}, 8'h01);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (90000) @(negedge clk);
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		check({7'h00, int_n}, 8'h01);
		lp_pin = 1'b0;
		expect_within(4, 8'h01, 300 * MSC);
		expect_within(1, 8'h0F, 400 * MSC);
		expect_within(2, 8'h0F, 100 * MSC);
		$display("power up test done");
		rx_los[0] = 1'b1;
		tx_lol[1] = 1'b1;
		rx_lol[2] = 1'b1;
		expect_within(0, 8'h00, 100 * MSC);
		rx_los = 4'h0;
		tx_lol = 4'h0;
		rx_lol = 4'h0;
		rd(`MMFT_OFF_LOS, 3);
		check(host_u.rbuf[0], 8'h01);
		check(host_u.rbuf[1], 8'h00);
		check(host_u.rbuf[2], 8'h24);
		expect_within(0, 8'h01, MSC / 2);
		rd(`MMFT_OFF_LOS, 3);
		check(host_u.rbuf[0], 8'h00);
		check(host_u.rbuf[2], 8'h00);
		$display("flag test done");
		rx_los[1] = 1'b1;
		expect_within(0, 8'h00, 200 * MSC);
		wr(`MMFT_OFF_MASK_LOS, 8'h02);
		expect_within(0, 8'h01, 100 * MSC);
		wr(`MMFT_OFF_MASK_LOS, 8'h00);
		expect_within(0, 8'h00, 100 * MSC);
		rx_los[1] = 1'b0;
		rd(`MMFT_OFF_LOS, 1);
		check(host_u.rbuf[0], 8'h02);
		expect_within(0, 8'h01, MSC / 2);
		$display("mask test done");
		wr(`MMFT_OFF_TXDIS, 8'h09);
		expect_within(1, 8'h06, 100 * MSC);
		wr(`MMFT_OFF_TXDIS, 8'h00);
		expect_within(1, 8'h0F, 400 * MSC);
		wr(`MMFT_OFF_PAGE, `MMFT_PAGE_CTL);
		wr(`MMFT_OFF_RXDIS, 8'hA0);
		expect_within(2, 8'h05, 100 * MSC);
		wr(`MMFT_OFF_RXDIS, 8'h00);
		expect_within(2, 8'h0F, 100 * MSC);
		$display("disable test done");
		tx_los[2] = 1'b1;
		rx_los[3] = 1'b1;
		expect_within(1, 8'h0B, 400 * MSC);
		check({4'h0, rx_en}, 8'h0F);
		wr(`MMFT_OFF_SQDIS, 8'h04);
		expect_within(1, 8'h0F, 100 * MSC);
		wr(`MMFT_OFF_SQDIS, 8'h00);
		expect_within(1, 8'h0B, 100 * MSC);
		tx_los[2] = 1'b0;
		rx_los[3] = 1'b0;
		expect_within(1, 8'h0F, 400 * MSC);
		$display("squelch test done");
		ce = 1'b0;
		lp_pin = 1'b1;
		repeat (20) @(negedge clk);
		check({7'h00, low_power}, 8'h00);
		ce = 1'b1;
		expect_within(3, 8'h01, 100 * MSC);
		lp_pin = 1'b0;
		expect_within(4, 8'h01, 300 * MSC);
		wr(`MMFT_OFF_PWR, 8'h03);
		expect_within(3, 8'h01, 100 * MSC);
		wr(`MMFT_OFF_PWR, 8'h00);
		expect_within(4, 8'h01, 300 * MSC);
		$display("power test done");
		host_u.xfer(7'h51, 1'b0, 8'h00, 8'h00, 1);
		@(negedge clk);
		check({7'h00, host_u.ack_ok}, 8'h00);
		host_u.abort();
		@(negedge clk);
		check({7'h00, host_u.ack_ok}, 8'h01);
		expect_within(5, 8'h00, 100 * MSC);
		$display("bus test done");
		tally_and_finish();
	end
endmodule // tb

// File: shared/mmft_params.svh
`ifndef MMFT_PARAMS_SVH
`define MMFT_PARAMS_SVH

`define MMFT_DEV_ADDR 7'h50

// lower page byte offsets and upper page base
`define MMFT_OFF_LOS 8'h03
`define MMFT_OFF_FAULT 8'h04
`define MMFT_OFF_LOL 8'h05
`define MMFT_OFF_TXDIS 8'h56
`define MMFT_OFF_PWR 8'h5D
`define MMFT_OFF_MASK_LOS 8'h64
`define MMFT_OFF_MASK_FAULT 8'h65
`define MMFT_OFF_MASK_LOL 8'h66
`define MMFT_OFF_PAGE 8'h7F
`define MMFT_UPPER_BASE 8'h80

// upper page holding lane controls
`define MMFT_PAGE_CTL 8'h03
`define MMFT_OFF_SQDIS 8'hF0
`define MMFT_OFF_RXDIS 8'hF1

// power byte fields
`define MMFT_PWR_OVR_BIT 0
`define MMFT_PWR_SET_BIT 1

// reset values
`define MMFT_RST_BYTE 8'h00
`define MMFT_RST_LANES 4'h0
`define MMFT_RST_PWR 2'h0

// timing
`define MMFT_CLK_HZ 50000000
`define MMFT_MS_CYCLES (`MMFT_CLK_HZ / 1000)
`define MMFT_T_PDOWN_OFF_MS 300
`define MMFT_PWR_SETTLE_MS 9'h002

`endif

// File: shared/mmft_pkg.sv
package mmft_pkg;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_ADDR_ACK,
		LS_WR,
		LS_WR_ACK,
		LS_RD,
		LS_RD_ACK
	} mmft_lstate_t;

	// link-side state
	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic sel_m;
		logic sel_s;
		logic ack_m;
		logic ack_s;
		mmft_lstate_t state;
		logic [7:0] shift;
		logic [3:0] bitcnt;
		logic rw;
		logic first;
		logic [7:0] ptr;
		logic sda_oe;
		logic req_tgl;
		logic req_wr;
		logic [7:0] req_addr;
		logic [7:0] req_data;
	} mmft_link_t;

	// module-clock state
	typedef struct packed {
		logic req_m;
		logic req_s;
		logic req_p;
		logic ack_tgl;
		logic [7:0] rdata;
		logic [15:0] cond_m;
		logic [15:0] cond_s;
		logic lp_m;
		logic lp_s;
		logic [7:0] flag_los;
		logic [7:0] flag_lol;
		logic [7:0] mask_los;
		logic [7:0] mask_fault;
		logic [7:0] mask_lol;
		logic [3:0] txdis;
		logic [1:0] pwr;
		logic [7:0] page;
		logic [3:0] sqdis;
		logic [3:0] rxdis;
		logic [15:0] ms_cnt;
		logic [8:0] settle;
		logic ready;
		logic low_power;
		logic int_n;
		logic [3:0] tx_en;
		logic [3:0] rx_en;
	} mmft_main_t;

endpackage
